/* common/imft_pkg.sv */
// constants for the interrupt mask and fifo threshold block
package imft_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_IRQ_MASK = 8'h5C;
    localparam logic [7:0] OFS_BYTE_ORDER = 8'h64;
    localparam logic [7:0] OFS_FIFO_THR = 8'h68;
    localparam logic [7:0] OFS_RX_CFG = 8'h6C;
    // fixed byte order pattern
    localparam logic [31:0] BYTE_ORDER_VALUE = 32'h87654321;
    // implemented enable bits: 31, 25..23, 21..13, 11..0
    localparam logic [31:0] IRQ_MASK_RW = 32'h83BFEFFF;
    localparam logic [31:0] IRQ_MASK_RESET = 32'h00000000;
    // status / enable bit positions driven from the fifo levels and the dma count
    localparam int BIT_RX_DMA = 20;
    localparam int BIT_TX_SPACE = 9;
    localparam int BIT_TX_STS_LVL = 7;
    localparam int BIT_RX_DATA_LVL = 5;
    localparam int BIT_RX_STS_LVL = 3;
    // threshold fields
    localparam int THR_TX_SPACE_LSB = 24;
    localparam int THR_TX_STS_LSB = 16;
    localparam int THR_RX_SPACE_LSB = 8;
    localparam int THR_RX_STS_LSB = 0;
    localparam logic [31:0] FIFO_THR_RESET = 32'h48000000;
    // receive configuration fields
    localparam int ALIGN_LSB = 30;
    localparam int DMA_CNT_LSB = 16;
    localparam int DMA_CNT_W = 12;
    localparam logic [1:0] ALIGN_RESET = 2'h0;
    // end alignment codes and the word mask each one needs
    localparam logic [1:0] ALIGN_4 = 2'h0;
    localparam logic [1:0] ALIGN_16 = 2'h1;
    localparam logic [1:0] ALIGN_32 = 2'h2;
    localparam logic [2:0] WMASK_4 = 3'h0;
    localparam logic [2:0] WMASK_16 = 3'h3;
    localparam logic [2:0] WMASK_32 = 3'h7;
endpackage : imft_pkg

/* rtl/imft_core.sv */
// interrupt enable mask, byte order test, fifo thresholds, rx config
// Function
// - set enable bit passes source to line
// - status latching ignores the mask
// - software enable bit 31, all reset zero
// - tx stopped bit 25, rx stopped 24
// - drop half bit 23, tx completion 21
// - dma 20, timer 19, transceiver 18, power 17
// - error enables at bits 16 to 13
// - tx fifo enables at bits 11 to 7
// - rx fifo 6..3, pin events 2..0
// - byte order register returns fixed pattern
// - tx space threshold bits 31..24, reset 48h
// - tx free space above threshold raises interrupt
// - tx status used above threshold raises interrupt
// - rx free space below threshold raises interrupt
// - rx status used above threshold raises interrupt
// - pad words after buffer end to alignment
// - 12-bit dma count, interrupt when done
// - count decrements per non-pad word, rewrite allowed
// - alignment codes 4, 16, 32 bytes
// - dma complete raises status bit 20
`timescale 1ns/100ps
module imft_core (
    input wire logic sys_clk,
    input wire logic reset_n,
    // register port
    input wire logic reg_cs,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // latched status from the status register block
    input wire logic [31:0] interrupt_status_latch,
    // fifo levels
    input wire logic [7:0] tx_free_blocks,
    input wire logic [7:0] tx_status_used,
    input wire logic [7:0] rx_free_blocks,
    input wire logic [7:0] rx_status_used,
    // receive data fifo read side
    input wire logic rx_word_read,
    input wire logic rx_last_word,
    // level and dma done events toward the status register block, pad word flag, host interrupt line
    output logic tx_space_available_irq,
    output logic tx_status_level_irq,
    output logic rx_data_level_irq,
    output logic rx_status_level_irq,
    output logic rx_dma_done_irq,
    output logic rx_pad_word,
    output logic host_irq
);
    // ============================================================
    // register state
    logic [31:0] irq_mask, next_irq_mask;
    logic [31:0] fifo_thr, next_fifo_thr;
    logic [1:0] rx_align, next_rx_align;
    logic [11:0] rx_dma_word_count, next_rx_dma_word_count;
    logic rx_dma_done, next_rx_dma_done;
    logic [31:0] rdata, next_rdata;
    logic wr_mask, wr_thr, wr_rxcfg;

    // byte field of the threshold register
    function automatic logic [7:0] thr_field(input logic [31:0] r, input int lsb);
        thr_field = r[lsb +: 8];
    endfunction : thr_field

    assign wr_mask = reg_cs && reg_wr && (reg_addr == imft_pkg::OFS_IRQ_MASK);
    assign wr_thr = reg_cs && reg_wr && (reg_addr == imft_pkg::OFS_FIFO_THR);
    assign wr_rxcfg = reg_cs && reg_wr && (reg_addr == imft_pkg::OFS_RX_CFG);

    // ============================================================
    // register writes
    always_comb begin
        next_irq_mask = irq_mask;
        next_fifo_thr = fifo_thr;
        next_rx_align = rx_align;
        if (wr_mask) begin
            // reserved bits 30..26, 22, 12 stay zero
            next_irq_mask = reg_wdata & imft_pkg::IRQ_MASK_RW;
        end
        if (wr_thr) begin
            next_fifo_thr = reg_wdata;
        end
        if (wr_rxcfg) begin
            next_rx_align = reg_wdata[imft_pkg::ALIGN_LSB +: 2];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask <= imft_pkg::IRQ_MASK_RESET;
            fifo_thr <= imft_pkg::FIFO_THR_RESET;
            rx_align <= imft_pkg::ALIGN_RESET;
        end else begin
            irq_mask <= next_irq_mask;
            fifo_thr <= next_fifo_thr;
            rx_align <= next_rx_align;
        end
    end

    // ============================================================
    // receive dma word count
    // a host write wins over a same-cycle decrement so the new count starts clean
    always_comb begin
        next_rx_dma_word_count = rx_dma_word_count;
        next_rx_dma_done = 1'b0;
        if (wr_rxcfg) begin
            next_rx_dma_word_count = reg_wdata[imft_pkg::DMA_CNT_LSB +: imft_pkg::DMA_CNT_W];
        end else if (rx_word_read && !rx_pad_word && rx_dma_word_count != 12'h000) begin
            next_rx_dma_word_count = rx_dma_word_count - 12'h001;
            next_rx_dma_done = (rx_dma_word_count == 12'h001);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_dma_word_count <= 12'h000;
            rx_dma_done <= 1'b0;
        end else begin
            rx_dma_word_count <= next_rx_dma_word_count;
            rx_dma_done <= next_rx_dma_done;
        end
    end

    assign rx_dma_done_irq = rx_dma_done;

    // ============================================================
    // level comparisons, combinational levels to the status block
    assign tx_space_available_irq =
        tx_free_blocks > thr_field(fifo_thr, imft_pkg::THR_TX_SPACE_LSB);
    assign tx_status_level_irq =
        tx_status_used > thr_field(fifo_thr, imft_pkg::THR_TX_STS_LSB);
    assign rx_data_level_irq =
        rx_free_blocks < thr_field(fifo_thr, imft_pkg::THR_RX_SPACE_LSB);
    assign rx_status_level_irq =
        rx_status_used > thr_field(fifo_thr, imft_pkg::THR_RX_STS_LSB);

    // ============================================================
    // host interrupt line: mask gates only the output, status is untouched
    assign host_irq = |(interrupt_status_latch & irq_mask);

    // ============================================================
    // read data, registered; unmapped offsets read zero
    always_comb begin
        next_rdata = 32'h00000000;
        if (reg_cs && !reg_wr) begin
            unique case (reg_addr)
                imft_pkg::OFS_IRQ_MASK: next_rdata = irq_mask;
                imft_pkg::OFS_BYTE_ORDER: next_rdata = imft_pkg::BYTE_ORDER_VALUE;
                imft_pkg::OFS_FIFO_THR: next_rdata = fifo_thr;
                imft_pkg::OFS_RX_CFG: begin
                    next_rdata[imft_pkg::ALIGN_LSB +: 2] = rx_align;
                    next_rdata[imft_pkg::DMA_CNT_LSB +: imft_pkg::DMA_CNT_W] = rx_dma_word_count;
                end
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign reg_rdata = rdata;

    // ============================================================
    // end alignment padding (host drops the pad words)
    imft_rx_pad u_pad (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .align_sel(rx_align),
        .word_read(rx_word_read),
        .last_word(rx_last_word),
        .pad_word(rx_pad_word)
    );

    // ============================================================
    // checks
    sequence s_read_pattern;
        reg_cs && !reg_wr && reg_addr == imft_pkg::OFS_BYTE_ORDER;
    endsequence

    sequence s_last_word_taken;
        rx_word_read && !rx_pad_word && !wr_rxcfg && rx_dma_word_count == 12'h001;
    endsequence

    irq_gating_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        host_irq == |(interrupt_status_latch & irq_mask))
        else $error("interrupt line not gated by mask");
    mask_blocks_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (irq_mask == 32'h00000000) |-> !host_irq)
        else $error("masked source reached the line");
    mask_reserved_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (irq_mask & ~imft_pkg::IRQ_MASK_RW) == 32'h00000000)
        else $error("reserved mask bit set");
    mask_write_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_mask |=> irq_mask[31] == $past(reg_wdata[31]) && irq_mask[25:23] == $past(reg_wdata[25:23]))
        else $error("mask write not stored");
    byte_pattern_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_read_pattern |=> reg_rdata == 32'h87654321)
        else $error("byte order pattern wrong");
    tx_space_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        tx_space_available_irq == (tx_free_blocks > fifo_thr[31:24]))
        else $error("tx space level wrong");
    rx_level_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        rx_data_level_irq == (rx_free_blocks < fifo_thr[15:8]))
        else $error("rx data level wrong");
    status_levels_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        tx_status_level_irq == (tx_status_used > fifo_thr[23:16])
        && rx_status_level_irq == (rx_status_used > fifo_thr[7:0]))
        else $error("status level wrong");
    dma_done_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_last_word_taken |=> rx_dma_done_irq && rx_dma_word_count == 12'h000 ##1 !rx_dma_done_irq)
        else $error("dma completion pulse wrong");
    dma_dec_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (rx_word_read && !rx_pad_word && !wr_rxcfg && rx_dma_word_count != 12'h000)
        |=> rx_dma_word_count == $past(rx_dma_word_count) - 12'h001)
        else $error("dma count did not decrement");
endmodule : imft_core

/* rtl/imft_rx_pad.sv */
// receive end alignment padding sequencer
`timescale 1ns/100ps
module imft_rx_pad (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [1:0] align_sel,
    input wire logic word_read,
    input wire logic last_word,
    output logic pad_word
);
    typedef enum logic [0:0] {
        IMFT_PAD_IDLE = 1'b0,
        IMFT_PAD_FILL = 1'b1
    } imft_pad_state_t;

    imft_pad_state_t state, next_state;
    logic [2:0] word_pos, next_word_pos;
    logic [2:0] wmask;

    // words per alignment unit minus one; reserved code behaves as 4-byte
    always_comb begin
        unique case (align_sel)
            imft_pkg::ALIGN_16: wmask = imft_pkg::WMASK_16;
            imft_pkg::ALIGN_32: wmask = imft_pkg::WMASK_32;
            default: wmask = imft_pkg::WMASK_4;
        endcase
    end

    // pad words flagged while filling up to the boundary
    assign pad_word = (state == IMFT_PAD_FILL);

    // position counter and fill state
    always_comb begin
        next_state = state;
        next_word_pos = word_pos;
        if (word_read) begin
            next_word_pos = (word_pos + 3'h1) & wmask;
            unique case (state)
                IMFT_PAD_IDLE: begin
                    if (last_word && (((word_pos + 3'h1) & wmask) != 3'h0)) begin
                        next_state = IMFT_PAD_FILL;
                    end
                end
                IMFT_PAD_FILL: begin
                    if (((word_pos + 3'h1) & wmask) == 3'h0) begin
                        next_state = IMFT_PAD_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= IMFT_PAD_IDLE;
            word_pos <= 3'h0;
        end else begin
            state <= next_state;
            word_pos <= next_word_pos;
        end
    end

    pad_ends_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (state == IMFT_PAD_FILL && word_read && (((word_pos + 3'h1) & wmask) == 3'h0))
        |=> !pad_word) else $error("padding did not stop at boundary");
endmodule : imft_rx_pad

/* tb/imft_core_tb.sv */
// self-checking bench for the interrupt mask and fifo threshold block
`timescale 1ns/100ps
module imft_core_tb;
    logic sys_clk;
    logic reset_n;
    logic reg_cs;
    logic reg_wr;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic [31:0] interrupt_status_latch;
    logic [7:0] tx_free_blocks;
    logic [7:0] tx_status_used;
    logic [7:0] rx_free_blocks;
    logic [7:0] rx_status_used;
    logic rx_word_read;
    logic rx_last_word;
    logic tx_space_available_irq;
    logic tx_status_level_irq;
    logic rx_data_level_irq;
    logic rx_status_level_irq;
    logic rx_dma_done_irq;
    logic rx_pad_word;
    logic host_irq;
    logic [31:0] d;
    int error_cnt;
    int compares;

    imft_core uut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_cs(reg_cs), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .interrupt_status_latch(interrupt_status_latch), .tx_free_blocks(tx_free_blocks),
        .tx_status_used(tx_status_used), .rx_free_blocks(rx_free_blocks),
        .rx_status_used(rx_status_used), .rx_word_read(rx_word_read),
        .rx_last_word(rx_last_word), .tx_space_available_irq(tx_space_available_irq),
        .tx_status_level_irq(tx_status_level_irq), .rx_data_level_irq(rx_data_level_irq),
        .rx_status_level_irq(rx_status_level_irq), .rx_dma_done_irq(rx_dma_done_irq),
        .rx_pad_word(rx_pad_word), .host_irq(host_irq));
    imft_host_model host (.sys_clk(sys_clk), .reg_cs(reg_cs), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // ==========
    // helpers
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] unused;
        host.access(1'h1, a, v, unused);
    endtask : wr

    // one fifo word read, strobe held across exactly one edge
    task automatic word(input logic last);
        @(posedge sys_clk);
        #1;
        rx_word_read = 1'h1;
        rx_last_word = last;
        @(posedge sys_clk);
        #1;
        rx_word_read = 1'h0;
        rx_last_word = 1'h0;
    endtask : word

    task automatic print_verdict();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // ==========
    // scenarios
    task automatic reset_values();
        host.access(1'h0, 8'h5C, 32'h0, d);
        check("mask reset", d, imft_pkg::IRQ_MASK_RESET);
        host.access(1'h0, 8'h64, 32'h0, d);
        check("byte order", d, imft_pkg::BYTE_ORDER_VALUE);
        host.access(1'h0, 8'h68, 32'h0, d);
        check("thr reset", d, imft_pkg::FIFO_THR_RESET);
        host.access(1'h0, 8'h6C, 32'h0, d);
        check("rx cfg reset", d, 32'h00000000);
        check("irq masked", host_irq, 1'h0);
    endtask : reset_values

    // every mask bit alone: implemented bits gate their own status bit only, reserved bits pass nothing
    task automatic mask_map();
        wr(8'h5C, 32'hFFFFFFFF);
        host.access(1'h0, 8'h5C, 32'h0, d);
        check("mask bits", d, 32'h83BFEFFF);
        wr(8'h64, 32'h00000000);
        host.access(1'h0, 8'h64, 32'h0, d);
        check("byte order ro", d, imft_pkg::BYTE_ORDER_VALUE);
        host.access(1'h0, 8'h60, 32'h0, d);
        check("unmapped", d, 32'h00000000);
        for (int i = 0; i < 32; i++) begin
            wr(8'h5C, 32'h00000001 << i);
            interrupt_status_latch = 32'h00000001 << i;
            #1;
            check("irq on", host_irq, imft_pkg::IRQ_MASK_RW[i]);
            // inputs only ever move one small step after a rising edge
            @(posedge sys_clk);
            #1;
            interrupt_status_latch = ~(32'h00000001 << i);
            #1;
            check("irq off", host_irq, 1'h0);
        end
        wr(8'h5C, 32'h00000000);
    endtask : mask_map

    // each level right at and one past its threshold
    task automatic thresholds();
        wr(8'h68, 32'h10052003);
        host.access(1'h0, 8'h68, 32'h0, d);
        check("thr rw", d, 32'h10052003);
        {tx_free_blocks, tx_status_used, rx_free_blocks, rx_status_used} = 32'h10052003;
        #1;
        check("levels at", {tx_space_available_irq, tx_status_level_irq,
              rx_data_level_irq, rx_status_level_irq}, 32'h0);
        @(posedge sys_clk);
        #1;
        {tx_free_blocks, tx_status_used, rx_free_blocks, rx_status_used} = 32'h11061F04;
        #1;
        // mask is all zero here, so the levels must still rise
        check("levels past", {tx_space_available_irq, tx_status_level_irq,
              rx_data_level_irq, rx_status_level_irq}, 32'hF);
    endtask : thresholds

    // alignment set between packets; padding words read and thrown away
    task automatic pad_case(input logic [1:0] align, input int nreal, input int npad);
        wr(8'h6C, {align, 30'h0});
        for (int k = 0; k < nreal; k++) begin
            word(k == nreal - 1);
            check("pad start", rx_pad_word, (k == nreal - 1) && (npad > 0));
        end
        for (int k = 0; k < npad; k++) begin
            word(1'h0);
            check("pad run", rx_pad_word, k < npad - 1);
        end
    endtask : pad_case

    // count down with a rewrite before zero, then a read at zero
    task automatic dma_count();
        wr(8'h6C, 32'h00030000);
        word(1'h0);
        check("no done", rx_dma_done_irq, 1'h0);
        host.access(1'h0, 8'h6C, 32'h0, d);
        check("count dec", d, 32'h00020000);
        wr(8'h6C, 32'h00010000);
        word(1'h0);
        check("done", rx_dma_done_irq, 1'h1);
        @(posedge sys_clk);
        #1;
        check("done pulse", rx_dma_done_irq, 1'h0);
        word(1'h0);
        check("done at zero", rx_dma_done_irq, 1'h0);
        host.access(1'h0, 8'h6C, 32'h0, d);
        check("count zero", d, 32'h00000000);
    endtask : dma_count

    // ==========
    // clock, watchdog and main sequence
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        #100000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        reset_n = 1'h0;
        interrupt_status_latch = 32'h00000000;
        {tx_free_blocks, tx_status_used, rx_free_blocks, rx_status_used} = 32'h00000000;
        rx_word_read = 1'h0;
        rx_last_word = 1'h0;
        repeat (10) @(posedge sys_clk);
        #1;
        reset_n = 1'h1;
        reset_values();
        mask_map();
        thresholds();
        pad_case(2'h1, 2, 2);
        pad_case(2'h2, 5, 3);
        pad_case(2'h0, 3, 0);
        pad_case(2'h3, 5, 0);
        dma_count();
        print_verdict();
    end
endmodule : imft_core_tb

/* tb/imft_host_model.sv */
// host processor model driving the register port of the block
`timescale 1ns/100ps
module imft_host_model (
    input wire logic sys_clk,
    output logic reg_cs,
    output logic reg_wr,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata
);
    // ==========
    // idle bus after reset
    initial begin
        reg_cs = 1'h0;
        reg_wr = 1'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
    end

    // ==========
    // one access: held up to the taking edge, then released
    task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata);
        @(posedge sys_clk);
        #1;
        reg_cs = 1'h1;
        reg_wr = wr;
        reg_addr = addr;
        reg_wdata = wdata;
        @(posedge sys_clk);
        #1;
        reg_cs = 1'h0;
        reg_wr = 1'h0;
        // released lines show no stale value
        reg_addr = ~addr;
        reg_wdata = ~wdata;
        rdata = reg_rdata;
    endtask : access
endmodule : imft_host_model
